// *** verilog/lbps_top.v ***
`timescale 1ns/100ps
`default_nettype none
`include "lbps_regs.vh"
module lbps_top #(
  parameter OLP_PERIODS = `LBPS_OLP_PERIODS
) (
  input  wire REF_CLK_I,
  input  wire SRST_I,
  input  wire OSC_TICK_I,
  input  wire TURN_ON_INPUT_I,
  input  wire SUPPLY_OK_I,
  input  wire PULSE_DIM_INPUT_I,
  input  wire SW_CUR_HIGH_I,
  input  wire OUT_OVER_VOLT_I,
  input  wire OUT_UNDER_OVP_REL_I,
  input  wire SENSE_LOW_I,
  input  wire LED_OVER_CUR_I,
  output reg  REF_EN_O,
  output reg  BOOST_GATE_EN_O,
  output reg  DIM_GATE_EN_O,
  output reg  AMP_CONNECT_O,
  output reg  SS_CLAMP_O,
  output reg  FAULT_OUT_O,
  output reg  FAULT_OE_N_O
);
  // Comparator and pin inputs, all asynchronous
  wire       tick_w;
  wire       turn_on_w;
  wire       supply_ok_w;
  wire       dim_w;
  wire       sw_cur_w;
  wire       ovp_hi_w;
  wire       ovp_rel_w;
  wire       sense_low_w;
  wire       ocp_w;

  // Oscillator square wave
  lbps_sync u_sync_tick (
    .clk_i (REF_CLK_I),
    .rst_i (SRST_I),
    .d_i   (OSC_TICK_I),
    .q_o   (tick_w)
  );

  // Turn-on comparator, hysteresis upstream
  lbps_sync u_sync_on (
    .clk_i (REF_CLK_I),
    .rst_i (SRST_I),
    .d_i   (TURN_ON_INPUT_I),
    .q_o   (turn_on_w)
  );

  // Supply lockout, high when supply good
  lbps_sync u_sync_sup (
    .clk_i (REF_CLK_I),
    .rst_i (SRST_I),
    .d_i   (SUPPLY_OK_I),
    .q_o   (supply_ok_w)
  );

  // Pulse dimming input
  lbps_sync u_sync_dim (
    .clk_i (REF_CLK_I),
    .rst_i (SRST_I),
    .d_i   (PULSE_DIM_INPUT_I),
    .q_o   (dim_w)
  );

  // Switch current above its limit
  lbps_sync u_sync_swc (
    .clk_i (REF_CLK_I),
    .rst_i (SRST_I),
    .d_i   (SW_CUR_HIGH_I),
    .q_o   (sw_cur_w)
  );

  // Output divider at over-voltage level
  lbps_sync u_sync_ovh (
    .clk_i (REF_CLK_I),
    .rst_i (SRST_I),
    .d_i   (OUT_OVER_VOLT_I),
    .q_o   (ovp_hi_w)
  );

  // Output divider below release level
  lbps_sync u_sync_ovr (
    .clk_i (REF_CLK_I),
    .rst_i (SRST_I),
    .d_i   (OUT_UNDER_OVP_REL_I),
    .q_o   (ovp_rel_w)
  );

  // Sense feedback below open-string level
  lbps_sync u_sync_sen (
    .clk_i (REF_CLK_I),
    .rst_i (SRST_I),
    .d_i   (SENSE_LOW_I),
    .q_o   (sense_low_w)
  );

  // LED over-current, clamped threshold upstream
  lbps_sync u_sync_ocp (
    .clk_i (REF_CLK_I),
    .rst_i (SRST_I),
    .d_i   (LED_OVER_CUR_I),
    .q_o   (ocp_w)
  );

  // Oscillator tick edge gives one-cycle enable
  reg  tick_d1_q;
  wire osc_en_w;
  always @(posedge REF_CLK_I)
  begin
    if (SRST_I)
      tick_d1_q <= 1'b0;
    else
      tick_d1_q <= tick_w;
  end
  assign osc_en_w = tick_w & ~tick_d1_q;

  // Device runs only with enable and supply good
  wire run_w;
  assign run_w = turn_on_w & supply_ok_w;

  // Open-string arming and override state
  reg  armed_q;
  reg  force_dim_q;
  reg  fault_q;
  wire dim_int_w;
  assign dim_int_w = dim_w | force_dim_q;

  always @(posedge REF_CLK_I)
  begin
    if (SRST_I || !run_w)
      armed_q <= 1'b0;
    else if (dim_w)
      armed_q <= 1'b1;
  end

  // Over-voltage entry and release filters
  reg  ovp_q;
  wire ovp_set_w;
  wire ovp_clr_w;
  lbps_cnt #(.W(10), .LIMIT(`LBPS_OVP_SET_CYC)) u_ovp_set (
    .clk_i  (REF_CLK_I),
    .rst_i  (SRST_I),
    .clr_i  (!ovp_hi_w || ovp_q),
    .en_i   (1'b1),
    .done_o (ovp_set_w)
  );
  lbps_cnt #(.W(10), .LIMIT(`LBPS_OVP_CLR_CYC)) u_ovp_clr (
    .clk_i  (REF_CLK_I),
    .rst_i  (SRST_I),
    .clr_i  (!ovp_rel_w || !ovp_q),
    .en_i   (1'b1),
    .done_o (ovp_clr_w)
  );
  always @(posedge REF_CLK_I)
  begin
    if (SRST_I || !run_w)
      ovp_q <= 1'b0;
    else if (!ovp_q && ovp_set_w)
      ovp_q <= 1'b1;
    else if (ovp_q && ovp_clr_w)
      ovp_q <= 1'b0;
  end

  // Open-string condition, masked by over-voltage
  wire olp_cond_w;
  wire olp_5us_w;
  wire olp_blank_w;
  assign olp_cond_w = armed_q & dim_int_w & sense_low_w & ~ovp_q;
  lbps_cnt #(.W(8), .LIMIT(`LBPS_OLP_FORCE_CYC)) u_olp_force (
    .clk_i  (REF_CLK_I),
    .rst_i  (SRST_I),
    .clr_i  (!olp_cond_w),
    .en_i   (1'b1),
    .done_o (olp_5us_w)
  );
  lbps_cnt #(.W(14), .LIMIT(OLP_PERIODS)) u_olp_blank (
    .clk_i  (REF_CLK_I),
    .rst_i  (SRST_I),
    .clr_i  (!olp_cond_w),
    .en_i   (osc_en_w),
    .done_o (olp_blank_w)
  );
  always @(posedge REF_CLK_I)
  begin
    if (SRST_I || !run_w)
    begin
      force_dim_q <= 1'b0;
      fault_q     <= 1'b0;
    end
    else
    begin
      if (olp_5us_w)
        force_dim_q <= 1'b1;
      else if (!olp_cond_w && !fault_q)
        force_dim_q <= 1'b0;
      if (olp_blank_w)
        fault_q <= 1'b1;
    end
  end

  // Soft-start accumulates dim-high oscillator periods
  wire ss_done_w;
  lbps_cnt #(.W(10), .LIMIT(`LBPS_SS_PERIODS)) u_ss (
    .clk_i  (REF_CLK_I),
    .rst_i  (SRST_I),
    .clr_i  (!run_w),
    .en_i   (osc_en_w & dim_int_w),
    .done_o (ss_done_w)
  );

  // Over-current: 1us delay, then off with 128-period restart
  localparam [1:0] OC_IDLE = 2'h0;
  localparam [1:0] OC_WAIT = 2'h1;
  localparam [1:0] OC_OFF  = 2'h2;

  // Delay and restart limits, cut to counter width
  localparam integer OC_DLY_N = `LBPS_OCP_DLY_CYC;
  localparam integer OC_AR_N  = `LBPS_AR_PERIODS;
  localparam [4:0]   OC_DLY   = OC_DLY_N[4:0];
  localparam [7:0]   OC_AR    = OC_AR_N[7:0];

  // Over-current state and counters
  reg  [1:0] oc_state_q;
  reg  [4:0] oc_dly_q;
  reg  [7:0] oc_ar_q;
  always @(posedge REF_CLK_I)
  begin
    if (SRST_I || !run_w)
    begin
      oc_state_q <= OC_IDLE;
      oc_dly_q   <= 5'h00;
      oc_ar_q    <= 8'h00;
    end
    else
    begin
      case (oc_state_q)
        OC_IDLE:
        begin
          oc_dly_q <= 5'h01;
          if (ocp_w)
            oc_state_q <= OC_WAIT;
        end
        OC_WAIT:
        begin
          if (oc_dly_q >= OC_DLY)
          begin
            oc_state_q <= OC_OFF;
            oc_ar_q    <= 8'h00;
          end
          else
            oc_dly_q <= oc_dly_q + 5'h01;
        end
        OC_OFF:
        begin
          if (oc_ar_q == OC_AR)
            oc_state_q <= OC_IDLE;
          else if (osc_en_w)
            oc_ar_q <= oc_ar_q + 8'h01;
        end
        default:
          oc_state_q <= OC_IDLE;
      endcase
    end
  end

  // Per-cycle switch: on at tick, blanking, then current limit
  localparam integer LEB_N   = `LBPS_LEB_CYC;
  localparam [3:0]   LEB_CYC = LEB_N[3:0];
  reg  [3:0] leb_q;
  reg        on_q;
  always @(posedge REF_CLK_I)
  begin
    if (SRST_I || !run_w)
    begin
      on_q  <= 1'b0;
      leb_q <= 4'h0;
    end
    else if (osc_en_w)
    begin
      on_q  <= 1'b1;
      leb_q <= 4'h0;
    end
    else if (on_q)
    begin
      if (leb_q != LEB_CYC)
        leb_q <= leb_q + 4'h1;
      else if (sw_cur_w)
        on_q <= 1'b0;
    end
  end

  // Gate permission from dimming and protections
  wire gates_ok_w;
  assign gates_ok_w = run_w & dim_int_w & ~ovp_q & (oc_state_q != OC_OFF);

  // Registered outputs
  always @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      REF_EN_O        <= 1'b0;
      BOOST_GATE_EN_O <= 1'b0;
      DIM_GATE_EN_O   <= 1'b0;
      AMP_CONNECT_O   <= 1'b0;
      SS_CLAMP_O      <= 1'b1;
      FAULT_OUT_O     <= 1'b0;
      FAULT_OE_N_O    <= 1'b0;
    end
    else
    begin
      REF_EN_O        <= run_w;
      BOOST_GATE_EN_O <= gates_ok_w & on_q;
      DIM_GATE_EN_O   <= gates_ok_w;
      AMP_CONNECT_O   <= run_w & dim_int_w;
      SS_CLAMP_O      <= ~ss_done_w;
      FAULT_OUT_O     <= 1'b0;
      FAULT_OE_N_O    <= fault_q;
    end
  end
endmodule // lbps_top
`default_nettype wire

// *** verilog/lbps_regs.vh ***
`ifndef LBPS_REGS_VH
`define LBPS_REGS_VH
// Reference clock, blanking time in nanoseconds and microsecond delays
`define LBPS_CLK_MHZ        25
`define LBPS_LEB_NS         300
`define LBPS_OLP_FORCE_US   5
`define LBPS_OVP_SET_US     20
`define LBPS_OVP_CLR_US     14
`define LBPS_OCP_DLY_US     1
// Derived cycle counts, least times round up
`define LBPS_LEB_CYC        ((`LBPS_LEB_NS * `LBPS_CLK_MHZ + 999) / 1000)
`define LBPS_OLP_FORCE_CYC  (`LBPS_OLP_FORCE_US * `LBPS_CLK_MHZ)
`define LBPS_OVP_SET_CYC    (`LBPS_OVP_SET_US * `LBPS_CLK_MHZ)
`define LBPS_OVP_CLR_CYC    (`LBPS_OVP_CLR_US * `LBPS_CLK_MHZ)
`define LBPS_OCP_DLY_CYC    (`LBPS_OCP_DLY_US * `LBPS_CLK_MHZ)
// Oscillator period counts
`define LBPS_SS_PERIODS     600
`define LBPS_OLP_PERIODS    8192
`define LBPS_AR_PERIODS     128
`endif

// *** verilog/lbps_sync.v ***
`timescale 1ns/100ps
`default_nettype none
// Two flip-flop synchroniser for a vector of pins
module lbps_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;

  // First stage feeds only the second
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end
    else
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end

  assign q_o = s2_q;
endmodule // lbps_sync
`default_nettype wire

// *** verilog/lbps_cnt.v ***
`timescale 1ns/100ps
`default_nettype none
// Saturating counter: counts on enable, clears on clear, flags reaching limit
module lbps_cnt #(
  parameter W     = 16,
  parameter LIMIT = 16
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire clr_i,
  input  wire en_i,
  output wire done_o
);
  localparam [W-1:0] LIM = LIMIT[W-1:0];
  reg [W-1:0] cnt_q;

  // Count up to the limit and hold
  always @(posedge clk_i)
  begin
    if (rst_i || clr_i)
      cnt_q <= {W{1'b0}};
    else if (en_i && cnt_q != LIM)
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
  end

  assign done_o = (cnt_q == LIM);
endmodule // lbps_cnt
`default_nettype wire

// *** sim/lbps_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
// Protection and sequencing checks at the top ports
module lbps_properties (
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic SUPPLY_OK_I,
  input wire logic PULSE_DIM_INPUT_I,
  input wire logic OUT_OVER_VOLT_I,
  input wire logic LED_OVER_CUR_I,
  input wire logic REF_EN_O,
  input wire logic BOOST_GATE_EN_O,
  input wire logic DIM_GATE_EN_O,
  input wire logic AMP_CONNECT_O,
  input wire logic FAULT_OUT_O,
  input wire logic FAULT_OE_N_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);
  logic [9:0] ovp_q;
  logic [9:0] ocp_q;
  // Persistence of the over-voltage and over-current comparators, saturating
  always_ff @(posedge REF_CLK_I)
  begin
    ovp_q <= (SRST_I || !OUT_OVER_VOLT_I) ? 10'h0 : ovp_q + {9'h0, ~&ovp_q};
    ocp_q <= (SRST_I || !LED_OVER_CUR_I) ? 10'h0 : ocp_q + {9'h0, ~&ocp_q};
  end
  // Supply gone long enough to pass the synchroniser
  sequence supply_gone;
    !SUPPLY_OK_I [*6];
  endsequence
  a_supply_loss_off: assert property (supply_gone |-> !REF_EN_O && !DIM_GATE_EN_O)
    else $error("gates on after supply loss");
  // Dim pin high, then the device running when it reaches the outputs
  sequence dim_seen;
    PULSE_DIM_INPUT_I ##3 REF_EN_O;
  endsequence
  a_amp_with_dim: assert property (DIM_GATE_EN_O |-> AMP_CONNECT_O)
    else $error("dim gate on with amplifier disconnected");
  a_amp_follows_dim: assert property (dim_seen |-> AMP_CONNECT_O)
    else $error("amplifier not connected while dim high");
  a_boost_needs_dim: assert property (BOOST_GATE_EN_O |-> DIM_GATE_EN_O)
    else $error("boost gate on without dim gate");
  a_gates_need_ref: assert property (DIM_GATE_EN_O |-> REF_EN_O)
    else $error("gate on without reference");
  a_fault_pin_low: assert property (FAULT_OUT_O == 1'b0)
    else $error("fault pin drives high");
  a_fault_when_run: assert property ($rose(FAULT_OE_N_O) |-> REF_EN_O)
    else $error("fault raised while stopped");
  a_ovp_gates_off: assert property (ovp_q > 10'h1ff |-> !DIM_GATE_EN_O && !BOOST_GATE_EN_O)
    else $error("gates on under over-voltage");
  a_ocp_gates_off: assert property (ocp_q > 10'h20 && ocp_q < 10'hc8 |-> !DIM_GATE_EN_O)
    else $error("gates on under over-current");
endmodule // lbps_properties
bind lbps_top lbps_properties u_props (.*);
`default_nettype wire

// *** sim/lbps_stage.sv ***
`timescale 1ns/100ps
`default_nettype none
// Oscillator, fault pull-up and system power switch
module lbps_stage #(
  parameter int HALF = 10
) (
  input  wire logic clk_i,
  input  wire logic sup_req_i,
  input  wire logic fault_out_i,
  input  wire logic fault_oe_n_i,
  output var  logic tick_o,
  output wire logic sup_ok_o,
  output wire logic fault_line_o
);
  int n = 0;
  logic trip_q = 1'b0;
  initial tick_o = 1'b0;
  // Free-running switching oscillator
  always @(negedge clk_i)
  begin
    n = (n + 1) % HALF;
    if (n == 0)
      tick_o <= ~tick_o;
  end
  // Released pin reads high through the pull-up
  assign fault_line_o = fault_oe_n_i ? 1'b1 : fault_out_i;
  // System stays powered down after a fault until power is requested anew
  always @(negedge clk_i)
  begin
    if (!sup_req_i)
      trip_q <= 1'b0;
    else if (fault_line_o)
      trip_q <= 1'b1;
  end
  // Power removed while the fault line is high
  assign sup_ok_o = sup_req_i & ~fault_line_o & ~trip_q;
endmodule // lbps_stage
`default_nettype wire

// *** sim/lbps_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module lbps_top_tb;
  logic clk = 1'b0, srst = 1'b1, on_in = 1'b0, sup = 1'b0, dim = 1'b0, swc = 1'b0;
  logic ovp = 1'b0, rel = 1'b1, sen = 1'b0, ocp = 1'b0;
  wire  tick, sup_ok, ref_en, bst, dmg, amp, ss, fo, foe, fline;
  int   errors = 0, comparisons = 0;
  always #20 clk = ~clk;
  lbps_stage stage (.clk_i(clk), .sup_req_i(sup), .fault_out_i(fo), .fault_oe_n_i(foe), .tick_o(tick),
    .sup_ok_o(sup_ok), .fault_line_o(fline));
  lbps_top #(.OLP_PERIODS(16)) dut (.REF_CLK_I(clk), .SRST_I(srst), .OSC_TICK_I(tick), .TURN_ON_INPUT_I(on_in),
    .SUPPLY_OK_I(sup_ok), .PULSE_DIM_INPUT_I(dim), .SW_CUR_HIGH_I(swc), .OUT_OVER_VOLT_I(ovp),
    .OUT_UNDER_OVP_REL_I(rel), .SENSE_LOW_I(sen), .LED_OVER_CUR_I(ocp), .REF_EN_O(ref_en),
    .BOOST_GATE_EN_O(bst), .DIM_GATE_EN_O(dmg), .AMP_CONNECT_O(amp), .SS_CLAMP_O(ss),
    .FAULT_OUT_O(fo), .FAULT_OE_N_O(foe));
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task tk(input int n);
    repeat (n) @(posedge tick);
    @(negedge clk);
  endtask
  task check(input string nm, input logic s, input logic e);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, s);
    end
  endtask
  task conclude;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Bound on the whole run
  initial
  begin
    cyc(40000);
    errors++;
    conclude();
  end
  // Start-up, dimming, blanking, soft-start, protections
  initial
  begin
    cyc(10);
    srst = 1'b0;
    check("ss_clamp", ss, 1'b1);
    check("fault_oe_n", foe, 1'b0);
    on_in = 1'b1;
    cyc(10);
    check("ref_en", ref_en, 1'b0);
    sup = 1'b1;
    cyc(10);
    check("ref_en", ref_en, 1'b1);
    check("dim_gate", dmg, 1'b0);
    dim = 1'b1;
    tk(2);
    check("boost", bst, 1'b1);
    check("amp", amp, 1'b1);
    @(posedge tick);
    swc = 1'b1;
    cyc(6);
    check("boost_blank", bst, 1'b1);
    cyc(10);
    check("boost_cut", bst, 1'b0);
    swc = 1'b0;
    tk(300);
    dim = 1'b0;
    tk(200);
    check("amp", amp, 1'b0);
    check("ss_clamp", ss, 1'b1);
    dim = 1'b1;
    tk(280);
    check("ss_clamp", ss, 1'b1);
    tk(30);
    check("ss_clamp", ss, 1'b0);
    ovp = 1'b1;
    rel = 1'b0;
    cyc(480);
    check("dim_gate", dmg, 1'b1);
    cyc(40);
    check("dim_gate", dmg, 1'b0);
    ovp = 1'b0;
    rel = 1'b1;
    cyc(300);
    check("dim_gate", dmg, 1'b0);
    cyc(60);
    check("dim_gate", dmg, 1'b1);
    ocp = 1'b1;
    cyc(20);
    check("dim_gate", dmg, 1'b1);
    cyc(20);
    ocp = 1'b0;
    check("dim_gate", dmg, 1'b0);
    tk(100);
    check("dim_gate", dmg, 1'b0);
    tk(40);
    check("dim_gate", dmg, 1'b1);
    check("fault_oe_n", foe, 1'b0);
    sen = 1'b1;
    cyc(150);
    dim = 1'b0;
    cyc(10);
    check("dim_forced", dmg, 1'b1);
    check("fault_early", fline, 1'b0);
    for (int i = 0; i < 2000 && fline !== 1'b1; i++)
      @(negedge clk);
    check("fault_line", fline, 1'b1);
    cyc(6);
    check("ref_en", ref_en, 1'b0);
    conclude();
  end
endmodule // lbps_top_tb
`default_nettype wire
